//--- verilog/osf_map.vh
// osf_map.vh: register offsets, field positions, reset values and counts
// for the oscillator status flags block.
// assumes: included by bare name from design files under verilog/.
`ifndef OSF_MAP_VH
`define OSF_MAP_VH

// byte addresses on the AXI4-Lite register port
`define OSF_OFS_STATUS 8'h00
`define OSF_OFS_CONTROL 8'h04
`define OSF_OFS_SOURCE 8'h08

// oscillator_status field positions
`define OSF_STS_HF_STABLE 0
`define OSF_STS_LF_READY 1
`define OSF_STS_HF_READY 4
`define OSF_STS_SEC_READY 7

// control field positions and reset values
`define OSF_CTL_SEC_ENABLE 0
`define OSF_RST_SEC_ENABLE 1'h0

// source status field positions
`define OSF_SRC_HF_DRIVES 0
`define OSF_SRC_CNT_LSB 16

// cycles the high-frequency oscillator must stay ready before takeover
`define OSF_HF_SETTLE_CYC 16'h0010

// AXI response codes
`define OSF_RESP_OKAY 2'h0
`define OSF_RESP_SLVERR 2'h2

`endif

//--- verilog/osf_sync.v
// osf_sync.v: two flip-flop synchroniser, one per bit.
// assumes: inputs are asynchronous levels; nrst is synchronous, active low.
`timescale 1ns/100ps

module osf_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // levels
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1_ff;
      reg stage2_ff;
      // stage1 feeds stage2 only, to keep metastability out of logic
      always @(posedge clk_sys) begin
        if (!nrst) begin
          stage1_ff <= 1'b0;
          stage2_ff <= 1'b0;
        end else begin
          stage1_ff <= asyncIn[i];
          stage2_ff <= stage1_ff;
        end
      end
      assign syncOut[i] = stage2_ff;
    end
  endgenerate

endmodule // osf_sync

//--- verilog/osf_top.v
// osf_top.v: oscillator status flags with an AXI4-Lite register port.
// assumes: oscillator ready levels arrive from other clock domains and
// are synchronised here; the clock mux outside follows hfDrivesIntOsc.
//
// Behaviour
// - low-frequency oscillator ready flag at bit 1 reads its readiness.
// - high-frequency oscillator ready flag at bit 4 reads its readiness.
// - stable flag at bit 0 is 1 once 16 MHz oscillator drives clock.
// - until stable, start-up oscillator drives the clock; stable reads 0.
// - bits 6, 3 and 2 read 0; writes to the status register do nothing.
`timescale 1ns/100ps
`include "osf_map.vh"

module osf_top #(
  parameter ADDR_W = 8,
  parameter [15:0] SETTLE_CYC = `OSF_HF_SETTLE_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // oscillator ready levels, asynchronous
  input wire secOscReadyIn,
  input wire hfOscReadyIn,
  input wire lfOscReadyIn,
  // internal oscillator clock source select
  output wire hfDrivesIntOsc,
  output wire startupDrivesIntOsc,
  // secondary oscillator enable towards the oscillator driver
  output wire secondaryOscEnable
);

  ////////////////////////////////////////////////////////////////////////
  // synchronise the oscillator ready levels

  wire [2:0] readySync;
  wire secReady;
  wire hfReady;
  wire lfReady;

  osf_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .asyncIn({secOscReadyIn, hfOscReadyIn, lfOscReadyIn}),
    .syncOut(readySync)
  );

  assign secReady = readySync[2];
  assign hfReady = readySync[1];
  assign lfReady = readySync[0];

  ////////////////////////////////////////////////////////////////////////
  // high-frequency oscillator stability and clock takeover

  reg [15:0] settleCnt_ff;
  reg [15:0] nxt_settleCnt;
  reg hfStable_ff;
  reg nxt_hfStable;

  // ready must hold for SETTLE_CYC cycles; a drop of ready at any time
  // hands the clock straight back to the start-up oscillator
  always @* begin
    nxt_settleCnt = settleCnt_ff;
    nxt_hfStable = hfStable_ff;
    if (!hfReady) begin
      nxt_settleCnt = 16'h0000;
      nxt_hfStable = 1'b0;
    end else if (!hfStable_ff) begin
      if (settleCnt_ff >= SETTLE_CYC - 16'h0001) begin
        nxt_hfStable = 1'b1;
      end else begin
        nxt_settleCnt = settleCnt_ff + 16'h0001;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      settleCnt_ff <= 16'h0000;
      hfStable_ff <= 1'b0;
    end else begin
      settleCnt_ff <= nxt_settleCnt;
      hfStable_ff <= nxt_hfStable;
    end
  end

  assign hfDrivesIntOsc = hfStable_ff;
  assign startupDrivesIntOsc = ~hfStable_ff;

  ////////////////////////////////////////////////////////////////////////
  // control register and status composition

  reg secEnable_ff;
  wire secReadyFlag;
  wire [7:0] statusByte;
  wire [31:0] sourceWord;

  assign secondaryOscEnable = secEnable_ff;
  // a disabled secondary oscillator never holds anyone up
  assign secReadyFlag = secEnable_ff ? secReady : 1'b1;

  // unimplemented positions stay 0; start-up time-out status is not kept
  assign statusByte = {secReadyFlag,
                       1'b0,
                       1'b0,
                       hfReady,
                       2'b00,
                       lfReady,
                       hfStable_ff};

  assign sourceWord = {settleCnt_ff, 15'h0000, hfStable_ff};

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  reg awHeld_ff;
  reg [ADDR_W-1:0] awAddr_ff;
  reg wHeld_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg bValid_ff;
  reg [1:0] bResp_ff;
  wire awTake;
  wire wTake;
  wire doWrite;
  wire [7:0] wrOfs;

  // address and data are taken in either order and held until both exist
  assign s_axi_awready = ~awHeld_ff;
  assign s_axi_wready = ~wHeld_ff;
  assign awTake = s_axi_awvalid & ~awHeld_ff;
  assign wTake = s_axi_wvalid & ~wHeld_ff;
  assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;
  assign wrOfs = {awAddr_ff[7:2], 2'b00};

  always @(posedge clk_sys) begin
    if (!nrst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= {ADDR_W{1'b0}};
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= `OSF_RESP_OKAY;
      secEnable_ff <= `OSF_RST_SEC_ENABLE;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bValid_ff <= 1'b1;
        case (wrOfs)
          `OSF_OFS_STATUS: begin
            // read-only: the write is accepted and dropped
            bResp_ff <= `OSF_RESP_OKAY;
          end
          `OSF_OFS_CONTROL: begin
            bResp_ff <= `OSF_RESP_OKAY;
            if (wStrb_ff[0]) begin
              secEnable_ff <= wData_ff[`OSF_CTL_SEC_ENABLE];
            end
          end
          `OSF_OFS_SOURCE: begin
            bResp_ff <= `OSF_RESP_OKAY;
          end
          default: begin
            bResp_ff <= `OSF_RESP_SLVERR;
          end
        endcase
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  reg rValid_ff;
  reg [31:0] rData_ff;
  reg [1:0] rResp_ff;
  reg [31:0] nxt_rData;
  reg [1:0] nxt_rResp;
  wire arTake;
  wire [7:0] rdOfs;

  assign s_axi_arready = ~rValid_ff;
  assign arTake = s_axi_arvalid & ~rValid_ff;
  assign rdOfs = {s_axi_araddr[7:2], 2'b00};

  always @* begin
    nxt_rData = 32'h00000000;
    nxt_rResp = `OSF_RESP_OKAY;
    case (rdOfs)
      `OSF_OFS_STATUS: begin
        nxt_rData = {24'h000000, statusByte};
      end
      `OSF_OFS_CONTROL: begin
        nxt_rData = {31'h00000000, secEnable_ff};
      end
      `OSF_OFS_SOURCE: begin
        nxt_rData = sourceWord;
      end
      default: begin
        nxt_rResp = `OSF_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= `OSF_RESP_OKAY;
    end else if (arTake) begin
      rValid_ff <= 1'b1;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
    end else if (rValid_ff && s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

endmodule // osf_top

//--- tb/osf_chk_chk.sv
// osf_chk_chk.sv: port checker for osf_top, bound to every instance.
// assumes: one clock domain; status reads are not overlapped by writes.
`timescale 1ns/100ps
module osf_chk #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // read side of the register port
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  // oscillator levels and clock source
  input wire secOscReadyIn,
  input wire hfOscReadyIn,
  input wire lfOscReadyIn,
  input wire hfDrivesIntOsc,
  input wire startupDrivesIntOsc,
  input wire secondaryOscEnable
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_sts;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 0;
  endsequence
  // three quiet samples cover the two synchroniser stages
  sequence s_quiet;
    $stable({secOscReadyIn, hfOscReadyIn, lfOscReadyIn})[*3];
  endsequence
  property p_lf;
    s_quiet ##0 s_sts |=> s_axi_rdata[1] == $past(lfOscReadyIn);
  endproperty
  a_lf: assert property (p_lf) else $error("lf ready bit wrong");
  property p_hf;
    s_quiet ##0 s_sts |=> s_axi_rdata[4] == $past(hfOscReadyIn);
  endproperty
  a_hf: assert property (p_hf) else $error("hf ready bit wrong");
  property p_stb;
    s_sts |=> s_axi_rdata[0] == $past(hfDrivesIntOsc);
  endproperty
  a_stb: assert property (p_stb) else $error("stable bit wrong");
  property p_src;
    (!hfOscReadyIn)[*3] |=> startupDrivesIntOsc && !hfDrivesIntOsc;
  endproperty
  a_src: assert property (p_src) else $error("hf drives unready");
  property p_zero;
    s_sts |=> s_axi_rdata[6] == 0 && s_axi_rdata[3:2] == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("spare bit set");
  property p_sec;
    s_quiet ##0 s_sts |=> s_axi_rdata[7] ==
      (!$past(secondaryOscEnable) || $past(secOscReadyIn));
  endproperty
  a_sec: assert property (p_sec) else $error("sec ready bit wrong");
endmodule // osf_chk
bind osf_top osf_chk #(.ADDR_W(ADDR_W)) chk (.*);

//--- tb/osf_osc_model.sv
// osf_osc_model.sv: behavioural oscillator sources.
// assumes: oscReq is {sec, hf, lf}; oscLag is start-up time in cycles.
`timescale 1ns/100ps
module osf_osc_model (
  // clock
  input wire clk_sys,
  // requests and start-up time
  input wire [2:0] oscReq,
  input wire [3:0] oscLag,
  // ready levels
  output reg [2:0] readyOut
);
  reg [2:0] lastReq = 3'h0;
  reg [3:0] runCnt = 4'h0;
  initial readyOut = 3'h0;
  // ready drops at once but rises only after the start-up time
  always @(posedge clk_sys) begin
    lastReq <= oscReq;
    if (oscReq != lastReq)
      runCnt <= 4'h0;
    else if (runCnt != 4'hf)
      runCnt <= runCnt + 4'h1;
    // the edge that sees a new request still holds the old count,
    // so readiness may only rise once the request has settled
    if (oscReq == lastReq && runCnt >= oscLag)
      readyOut <= oscReq;
    else
      readyOut <= oscReq & readyOut;
  end
endmodule // osf_osc_model

//--- tb/osf_testbench.sv
// osf_testbench.sv: self-checking bench for osf_top.
// assumes: osf_chk bound by its own file; settle count shortened to 2.
`timescale 1ns/100ps
module testbench;
  reg clk_sys = 0, nrst = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire secOscReadyIn, hfOscReadyIn, lfOscReadyIn;
  wire hfDrivesIntOsc, startupDrivesIntOsc, secondaryOscEnable;
  reg [2:0] oscReq = 3'h0;
  reg [3:0] oscLag = 4'h3;
  integer bad_count = 0, n_tests = 0;
  reg [1:0] rs;
  reg [31:0] rd;
  osf_top #(.SETTLE_CYC(16'h0002)) uut (.*);
  osf_osc_model osc (.clk_sys(clk_sys), .oscReq(oscReq), .oscLag(oscLag),
    .readyOut({secOscReadyIn, hfOscReadyIn, lfOscReadyIn}));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // handshakes are judged at the falling edge, acted on at the rising one
  task axiWr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg aw, w, b;
    begin
      b = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b) begin
        @(negedge clk_sys);
        aw = s_axi_awvalid && s_axi_awready;
        w = s_axi_wvalid && s_axi_wready;
        b = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clk_sys);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task axiRd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ar, v;
    begin
      v = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!v) begin
        @(negedge clk_sys);
        ar = s_axi_arvalid && s_axi_arready;
        v = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk_sys);
        if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task t_hf;
    begin
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h80);
      oscReq <= 3'h2;
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h80);
      chk({hfDrivesIntOsc, startupDrivesIntOsc}, 2'h1);
      tick(20);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h91);
      chk({hfDrivesIntOsc, startupDrivesIntOsc}, 2'h2);
      oscReq <= 3'h0;
      tick(6);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h80);
      chk({hfDrivesIntOsc, startupDrivesIntOsc}, 2'h1);
      $display("t_hf done");
    end
  endtask
  task t_lf;
    begin
      oscReq <= 3'h1;
      tick(10);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h82);
      oscReq <= 3'h0;
      tick(4);
      $display("t_lf done");
    end
  endtask
  task t_sec;
    begin
      oscLag <= 4'h8;
      axiWr(8'h04, 32'h1, rs);
      chk(rs, 2'h0);
      chk(secondaryOscEnable, 32'h1);
      axiRd(8'h04, rd, rs);
      chk(rd, 32'h1);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h00);
      oscReq <= 3'h4;
      tick(20);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h80);
      oscReq <= 3'h0;
      tick(4);
      axiWr(8'h04, 32'h0, rs);
      chk(secondaryOscEnable, 32'h0);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h80);
      $display("t_sec done");
    end
  endtask
  task t_wr;
    begin
      axiWr(8'h00, 32'hffffffff, rs);
      chk(rs, 2'h0);
      axiRd(8'h00, rd, rs);
      chk(rd, 32'h80);
      chk(rs, 2'h0);
      axiWr(8'h0c, 32'h1, rs);
      chk(rs, 2'h2);
      axiRd(8'h0c, rd, rs);
      chk(rs, 2'h2);
      chk(rd, 32'h0);
      $display("t_wr done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    tick(8);
    nrst <= 1'b1;
    tick(1);
    t_hf;
    t_lf;
    t_sec;
    t_wr;
    tally_and_finish;
  end
  // the tests need about 120 cycles
  initial begin
    tick(3000);
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule // testbench
